/* rsr_pkg.sv */
// Package for the reset and stop recovery block
// Operation
// - Low pin pulse of three cycles may reset; four cycles in run or stop mode always resets.
// - Stay in reset while pin low; leave on third edge after release, through the two synchroniser flops.
// - Reset caused by the pin sets the pin reset flag to one.
// - Pin is open-drain low reset indicator during internal reset delay or when GPIO enables.
// - Internal reset events in run mode drive the pin low until their delay expires; in stop mode they only set their flag.
// - Debugger reset request sets power-on flag and, in run mode only, resets chip, then self-clears.
// - Stop recovery holds CPU in reset 66 or 5000 oscillator cycles.
// - Stop recovery changes only watchdog and oscillator control registers.
// - Stop recovery enables and selects the internal oscillator.
// - On leaving reset, fetch vector from 0002H and 0003H into the PC.
package rsr_pkg;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_CAUSE = 32'h0000_0004;
    localparam logic [31:0] ADDR_MASK = 32'h0000_0008;
    localparam logic [31:0] ADDR_STAT = 32'h0000_000C;
    localparam int CTRL_DBG_RST = 0;
    localparam int CTRL_XTAL_EN = 1;
    localparam int CTRL_PIN_OUT = 2;
    localparam int CTRL_STOP = 3;
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_PIN = 1;
    localparam int CAUSE_BRN = 2;
    localparam int CAUSE_WDT = 3;
    localparam int CAUSE_SMR = 4;
    localparam logic [2:0] PIN_FILTER_CYCLES = 3'd4;
    localparam logic [12:0] SMR_CYC_NOXTAL = 13'd66;
    localparam logic [12:0] SMR_CYC_XTAL = 13'd5000;
    localparam logic [12:0] INT_RST_DELAY_DEF = 13'd64;
    localparam logic [15:0] VEC_LO_ADDR = 16'h0002;
    localparam logic [15:0] VEC_HI_ADDR = 16'h0003;
    localparam logic [4:0] CAUSE_RESET = 5'h01;
    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_RESET = 3'b001,
        ST_FETCH_LO = 3'b011,
        ST_FETCH_HI = 3'b010,
        ST_STOP = 3'b110,
        ST_SMR = 3'b111
    } rsr_state_type;
    typedef struct packed {
        logic brownout_event;
        logic watchdog_event;
        logic stop_wake;
    } rsr_event_type;
endpackage

/* rsr_reset_ctrl.sv */
// Reset controller with pin filter, indicator, debugger reset and stop recovery
`timescale 1ns/100ps
`default_nettype none
module rsr_reset_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe,
    input wire logic gpio_reset_out_en,
    input wire rsr_pkg::rsr_event_type events_i,
    output logic cpu_reset,
    output logic chip_reset,
    output logic osc_use_internal,
    output logic wdt_osc_ctrl_reset,
    output logic fetch_req,
    output logic [15:0] fetch_addr,
    input wire logic [7:0] fetch_data,
    output logic [15:0] pc_load,
    output logic pc_load_valid,
    output logic irq
);
    import rsr_pkg::*;

    logic pin_s1_r, pin_s2_r;
    logic [2:0] low_cnt_r;
    logic pin_low;
    logic dbg_rst_r, xtal_en_r, pin_out_en_r, stop_r;
    logic [4:0] cause_r, mask_r;
    logic [1:0] stat_r;
    logic [12:0] dly_r;
    logic int_hold_r;
    rsr_state_type state_r;
    logic [7:0] vec_lo_r;
    logic wr, rd;
    logic ev_brn, ev_wdt;

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign ev_brn = events_i.brownout_event;
    assign ev_wdt = events_i.watchdog_event;

    // Two flops before the filter; the first is read only by the second
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else begin
            pin_s1_r <= reset_pin_i;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Counts low cycles; synchroniser latency makes three a maybe, four a must
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_r <= 3'd0;
        end else if (pin_s2_r) begin
            low_cnt_r <= 3'd0;
        end else if (low_cnt_r != PIN_FILTER_CYCLES) begin
            low_cnt_r <= low_cnt_r + 3'd1;
        end
    end
    // Internal-reset drive of the pin is excluded so the indicator does not latch itself
    assign pin_low = (low_cnt_r == PIN_FILTER_CYCLES) && !int_hold_r;

    // Control register: debugger request clears itself during the reset it causes
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dbg_rst_r <= 1'b0;
            xtal_en_r <= 1'b0;
            pin_out_en_r <= 1'b0;
            stop_r <= 1'b0;
        end else begin
            if (wr && paddr == ADDR_CTRL) begin
                dbg_rst_r <= pwdata[CTRL_DBG_RST];
                xtal_en_r <= pwdata[CTRL_XTAL_EN];
                pin_out_en_r <= pwdata[CTRL_PIN_OUT];
                stop_r <= pwdata[CTRL_STOP];
            end
            if (state_r == ST_RESET) begin
                dbg_rst_r <= 1'b0;
            end
            if (state_r == ST_SMR) begin
                stop_r <= 1'b0;
                xtal_en_r <= 1'b0;
            end
        end
    end

    // Main sequencer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_RESET;
            dly_r <= INT_RST_DELAY_DEF;
            int_hold_r <= 1'b1;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (pin_low) begin
                        state_r <= ST_RESET;
                        dly_r <= 13'd1;
                    end else if (ev_brn || ev_wdt || dbg_rst_r) begin
                        state_r <= ST_RESET;
                        dly_r <= INT_RST_DELAY_DEF;
                        int_hold_r <= 1'b1;
                    end else if (stop_r) begin
                        state_r <= ST_STOP;
                    end
                end
                ST_RESET: begin
                    if (dly_r != 13'd0) begin
                        dly_r <= dly_r - 13'd1;
                    end else begin
                        int_hold_r <= 1'b0;
                        if (pin_s2_r && !int_hold_r) begin
                            state_r <= ST_FETCH_LO;
                        end
                    end
                end
                ST_STOP: begin
                    if (pin_low) begin
                        state_r <= ST_RESET;
                        dly_r <= 13'd1;
                    end else if (events_i.stop_wake) begin
                        state_r <= ST_SMR;
                        dly_r <= xtal_en_r ? SMR_CYC_XTAL - 13'd1 : SMR_CYC_NOXTAL - 13'd1;
                    end
                end
                ST_SMR: begin
                    if (dly_r != 13'd0) begin
                        dly_r <= dly_r - 13'd1;
                    end else begin
                        state_r <= ST_FETCH_LO;
                    end
                end
                ST_FETCH_LO: state_r <= ST_FETCH_HI;
                ST_FETCH_HI: state_r <= ST_RUN;
                default: state_r <= ST_RESET;
            endcase
        end
    end

    // Vector fetch: low address first as the PC high byte, then the high address byte completes the PC low byte
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vec_lo_r <= 8'h00;
            pc_load <= 16'h0000;
            pc_load_valid <= 1'b0;
        end else begin
            pc_load_valid <= 1'b0;
            if (state_r == ST_FETCH_LO) begin
                vec_lo_r <= fetch_data;
            end
            if (state_r == ST_FETCH_HI) begin
                pc_load <= {vec_lo_r, fetch_data};
                pc_load_valid <= 1'b1;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cpu_reset <= 1'b1;
            chip_reset <= 1'b1;
            reset_pin_o <= 1'b0;
            reset_pin_oe <= 1'b0;
            osc_use_internal <= 1'b1;
            wdt_osc_ctrl_reset <= 1'b0;
            fetch_req <= 1'b0;
            fetch_addr <= VEC_LO_ADDR;
        end else begin
            cpu_reset <= (state_r != ST_RUN);
            chip_reset <= (state_r == ST_RESET);
            reset_pin_o <= 1'b0;
            // Open drain: enable low means the pin is pulled low
            reset_pin_oe <= !((state_r == ST_RESET && int_hold_r) || pin_out_en_r || gpio_reset_out_en);
            osc_use_internal <= (state_r == ST_SMR) ? 1'b1 : osc_use_internal & ~stop_r;
            wdt_osc_ctrl_reset <= (state_r == ST_SMR);
            fetch_req <= (state_r == ST_SMR && dly_r == 13'd0) || (state_r == ST_RESET && dly_r == 13'd0)
                || (state_r == ST_FETCH_LO);
            fetch_addr <= (state_r == ST_FETCH_LO) ? VEC_HI_ADDR : VEC_LO_ADDR;
        end
    end

    // Cause register: sticky, cleared by writing ones; a new cause wins over a clear
    logic [4:0] cause_set;
    always_comb begin
        cause_set = 5'h00;
        if (state_r == ST_RUN || state_r == ST_STOP) begin
            cause_set[CAUSE_PIN] = pin_low;
            cause_set[CAUSE_BRN] = ev_brn && !pin_low;
            cause_set[CAUSE_WDT] = ev_wdt && !pin_low;
            cause_set[CAUSE_POR] = dbg_rst_r && !pin_low && !ev_brn && !ev_wdt;
        end
        cause_set[CAUSE_SMR] = (state_r == ST_STOP) && events_i.stop_wake && !pin_low;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cause_r <= CAUSE_RESET;
            stat_r <= 2'b00;
            mask_r <= 5'h00;
        end else begin
            cause_r <= (cause_r & ~((wr && paddr == ADDR_CAUSE) ? pwdata[4:0] : 5'h00)) | cause_set;
            // A reset that is still on wins over a clear in the same cycle
            stat_r <= (stat_r & ~((wr && paddr == ADDR_STAT) ? pwdata[1:0] : 2'b00))
                | {pc_load_valid, chip_reset};
            if (wr && paddr == ADDR_MASK) begin
                mask_r <= pwdata[4:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            irq <= |(cause_r & mask_r);
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~(paddr == ADDR_CTRL || paddr == ADDR_CAUSE
                || paddr == ADDR_MASK || paddr == ADDR_STAT);
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    ADDR_CTRL: prdata <= {28'h000_0000, stop_r, pin_out_en_r, xtal_en_r, dbg_rst_r};
                    ADDR_CAUSE: prdata <= {27'h000_0000, cause_r};
                    ADDR_MASK: prdata <= {27'h000_0000, mask_r};
                    ADDR_STAT: prdata <= {24'h00_0000, 3'b000, state_r, stat_r};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    logic unused_rd;
    assign unused_rd = rd;

    property p_filter;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_RUN && !int_hold_r) ##0 (!pin_s2_r)[*4] |=> ##[0:1] (state_r == ST_RESET);
    endproperty
    a_filter: assert property (p_filter) else $error("Four low cycles did not reset");

    property p_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_RESET && !pin_s2_r) |=> (state_r == ST_RESET);
    endproperty
    a_hold: assert property (p_hold) else $error("Left reset while pin low");

    property p_pinflag;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_RUN && pin_low) |=> cause_r[CAUSE_PIN];
    endproperty
    a_pinflag: assert property (p_pinflag) else $error("Pin flag not set");

    property p_indicator;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_RESET && int_hold_r) |=> !reset_pin_oe;
    endproperty
    a_indicator: assert property (p_indicator) else $error("Pin not driven during reset");

    property p_intdrv;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_RUN && ev_wdt && !pin_low) |=> ##1 (!reset_pin_oe)[*8];
    endproperty
    a_intdrv: assert property (p_intdrv) else $error("Internal reset not held on pin");

    property p_dbg;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_RESET) |=> !dbg_rst_r;
    endproperty
    a_dbg: assert property (p_dbg) else $error("Debugger request not cleared");

    // Recovery length is counted, since a long repetition would not unroll
    logic [12:0] smr_len_r;
    logic smr_xtal_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            smr_len_r <= 13'h0000;
            smr_xtal_r <= 1'b0;
        end else begin
            smr_len_r <= (state_r == ST_SMR) ? smr_len_r + 13'h0001 : 13'h0000;
            if (state_r == ST_STOP && events_i.stop_wake) begin
                smr_xtal_r <= xtal_en_r;
            end
        end
    end

    property p_smr;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_FETCH_LO && smr_len_r != 13'h0000) |->
            (smr_len_r == (smr_xtal_r ? SMR_CYC_XTAL : SMR_CYC_NOXTAL));
    endproperty
    a_smr: assert property (p_smr) else $error("Stop recovery length wrong");

    property p_osc;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_SMR) |=> osc_use_internal && wdt_osc_ctrl_reset;
    endproperty
    a_osc: assert property (p_osc) else $error("Oscillator not reselected");

    property p_vec;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ST_FETCH_LO) |=> fetch_addr == VEC_HI_ADDR ##1 pc_load_valid;
    endproperty
    a_vec: assert property (p_vec) else $error("Vector fetch order wrong");
endmodule
`default_nettype wire

/* rsr_board_model.sv */
// Board model: reset pin with pull-up, external reset source and vector memory
`timescale 1ns/100ps
`default_nettype none
module rsr_board_model #(
    parameter logic [7:0] VEC_LO_BYTE = 8'hA5,
    parameter logic [7:0] VEC_HI_BYTE = 8'h3C
) (
    input wire logic clk_sys,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe,
    input wire logic ext_low,
    output logic reset_pin,
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    output logic [7:0] fetch_data
);
    import rsr_pkg::*;
    logic [7:0] junk_r = 8'h5A;
    // Pull-up wins unless the board source or the open-drain indicator pulls low
    assign reset_pin = ~(ext_low | (~reset_pin_oe & ~reset_pin_o));
    // Unselected memory shows a changing pattern so a stale byte never passes
    always_ff @(posedge clk_sys) begin
        junk_r <= ~junk_r + 8'h01;
    end
    always_comb begin
        if (fetch_req && fetch_addr == VEC_LO_ADDR) begin
            fetch_data = VEC_LO_BYTE;
        end else if (fetch_req && fetch_addr == VEC_HI_ADDR) begin
            fetch_data = VEC_HI_BYTE;
        end else begin
            fetch_data = junk_r;
        end
    end
endmodule
`default_nettype wire

/* rsr_tb.sv */
// Self-checking testbench for the reset and stop recovery block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; $display("wrong value at %0t: %s", $time, m); end end
module testbench;
    import rsr_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_low = 1'b0, gpio_en = 1'b0;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata, rd;
    rsr_event_type ev = 3'b000;
    logic [12:0] smr_cnt = 13'h0000, s0;
    logic [15:0] pc_seen = 16'h0000, fetch_addr, pc_load;
    logic [7:0] fetch_data;
    logic pready, pslverr, pin, pin_o, pin_oe, cpu_reset, chip_reset, osc_int, wdt_rst, fetch_req, pc_valid, irq, err;
    logic oe_low_seen = 1'b0;
    int n_mismatch = 0, cmp_count = 0;
    rsr_reset_ctrl i_rsr_reset_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_pin_i(pin), .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .gpio_reset_out_en(gpio_en),
        .events_i(ev), .cpu_reset(cpu_reset), .chip_reset(chip_reset), .osc_use_internal(osc_int),
        .wdt_osc_ctrl_reset(wdt_rst), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
        .pc_load(pc_load), .pc_load_valid(pc_valid), .irq(irq));
    rsr_board_model i_rsr_board_model (.clk_sys(clk_sys), .reset_pin_o(pin_o), .reset_pin_oe(pin_oe),
        .ext_low(ext_low), .reset_pin(pin), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_data(fetch_data));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // Recovery length, loaded vector and indicator drive are seen only at the ports
    always @(posedge clk_sys) begin
        if (wdt_rst === 1'b1) smr_cnt <= smr_cnt + 13'h0001;
        if (pc_valid === 1'b1) pc_seen <= pc_load;
        if (pin_oe === 1'b0) oe_low_seen <= 1'b1;
    end
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK(i < 16, 1'b1, "no bus answer")
        if (i >= 16) end_of_test;
    endtask
    // Waits on the CPU reset level; a lost handshake ends the run
    task automatic wait_cpu(input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge clk_sys);
            if (cpu_reset === v) return;
        end
        $display("wrong value at %0t: wait expired", $time);
        n_mismatch++;
        end_of_test;
    endtask
    task automatic pin_low(input int n);
        @(posedge clk_sys);
        ext_low <= 1'b1;
        repeat (n) @(posedge clk_sys);
        ext_low <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
        `CHK(pin_oe, 1'b0, "pin not driven in reset")
        `CHK(pin, 1'b0, "pin level in reset")
        wait_cpu(1'b0, 300);
        repeat (2) @(posedge clk_sys);
        `CHK(pc_seen, 16'hA53C, "vector after power-on")
        `CHK(pin_oe, 1'b1, "pin still driven")
        apb(1'b0, 32'h0000_0040, 32'h0000_0000);
        `CHK({err, rd}, {1'b1, 32'h0000_0000}, "unmapped read")
        apb(1'b0, ADDR_STAT, 32'h0000_0000);
        `CHK(rd, 32'h0000_0003, "status after power-on")
        apb(1'b1, ADDR_STAT, 32'h0000_0003);
        apb(1'b0, ADDR_STAT, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000, "status clear")
        $display("test power-on done");
        apb(1'b1, ADDR_CAUSE, 32'h0000_001F);
        apb(1'b1, ADDR_MASK, 32'h0000_0002);
        pin_low(2);
        repeat (8) @(posedge clk_sys);
        `CHK(cpu_reset, 1'b0, "short pulse reset")
        pin_low(4);
        wait_cpu(1'b1, 20);
        wait_cpu(1'b0, 300);
        @(posedge clk_sys);
        ext_low <= 1'b1;
        repeat (60) @(posedge clk_sys);
        `CHK(chip_reset, 1'b1, "left reset with pin low")
        ext_low <= 1'b0;
        pc_seen = 16'h0000;
        wait_cpu(1'b0, 300);
        repeat (2) @(posedge clk_sys);
        `CHK(pc_seen, 16'hA53C, "vector after pin reset")
        apb(1'b0, ADDR_CAUSE, 32'h0000_0000);
        `CHK(rd[CAUSE_PIN], 1'b1, "pin flag")
        `CHK(irq, 1'b1, "irq with pin flag")
        apb(1'b1, ADDR_CAUSE, 32'h0000_0002);
        repeat (2) @(posedge clk_sys);
        `CHK(irq, 1'b0, "irq after clear")
        $display("test pin done");
        gpio_en <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK(pin_oe, 1'b0, "gpio indicator")
        gpio_en <= 1'b0;
        wait_cpu(1'b0, 300);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, ADDR_CAUSE, 32'h0000_001F);
            oe_low_seen = 1'b0;
            ev <= rsr_event_type'({k == 0, k == 1, 1'b0});
            @(posedge clk_sys);
            ev <= 3'b000;
            wait_cpu(1'b1, 20);
            wait_cpu(1'b0, 300);
            `CHK(oe_low_seen, 1'b1, "no indicator on event")
            apb(1'b0, ADDR_CAUSE, 32'h0000_0000);
            `CHK(rd[CAUSE_BRN + k], 1'b1, "event flag")
        end
        apb(1'b1, ADDR_CAUSE, 32'h0000_001F);
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        wait_cpu(1'b1, 20);
        wait_cpu(1'b0, 300);
        apb(1'b0, ADDR_CTRL, 32'h0000_0000);
        `CHK(rd[CTRL_DBG_RST], 1'b0, "debug request stuck")
        apb(1'b0, ADDR_CAUSE, 32'h0000_0000);
        `CHK(rd[CAUSE_POR], 1'b1, "power-on flag")
        $display("test events done");
        for (int x = 0; x < 2; x++) begin
            apb(1'b1, ADDR_CAUSE, 32'h0000_001F);
            apb(1'b1, ADDR_MASK, 32'h0000_0010);
            apb(1'b1, ADDR_CTRL, x ? 32'h0000_000A : 32'h0000_0008);
            repeat (3) @(posedge clk_sys);
            `CHK(osc_int, 1'b0, "oscillator still internal")
            s0 = smr_cnt;
            pc_seen = 16'h0000;
            ev <= 3'b001;
            @(posedge clk_sys);
            ev <= 3'b000;
            wait_cpu(1'b1, 20);
            wait_cpu(1'b0, 6000);
            repeat (2) @(posedge clk_sys);
            `CHK(smr_cnt - s0, x ? SMR_CYC_XTAL : SMR_CYC_NOXTAL, "recovery length")
            `CHK(osc_int, 1'b1, "internal oscillator not selected")
            `CHK(pc_seen, 16'hA53C, "vector after recovery")
            `CHK(irq, 1'b1, "recovery irq")
            apb(1'b0, ADDR_MASK, 32'h0000_0000);
            `CHK(rd, 32'h0000_0010, "mask lost in recovery")
            apb(1'b0, ADDR_CTRL, 32'h0000_0000);
            `CHK(rd[CTRL_XTAL_EN], 1'b0, "crystal still enabled")
        end
        $display("test stop recovery done");
        end_of_test;
    end
endmodule
`default_nettype wire
